// [core/i2c_status_pkg.sv]
// shared constants and types for the two-wire status and address mask block
// Contract
// - at ack slot end, record whether the receiver acknowledged or not
// - start or repeated start sets begin flag; stop sets halt flag; latest wins
// - slave read address sets direction bit, write address clears it
// - direction bit changes only after the address byte is received
// - receive-full sets on receive load, clears when software reads receive data
// - transmit-full sets on software write, clears when the byte is shifted out
// - mask bit one makes address position don't-care, zero needs exact match
// - mask register has ten writable bits, upper six read zero
// - delay select one gives about 300 ns sda delay, zero about 150 ns
// - address masking applies only while management support mode is off
// - reserved addresses never match; general call only when enabled
package i2c_status_pkg;

  // ---------------------------------------------------------------
  // register port and map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] OFF_STAT = 3'h0;
  localparam logic [2:0] OFF_MSK = 3'h1;
  localparam logic [2:0] OFF_PAD = 3'h2;
  localparam logic [2:0] OFF_RCV = 3'h3;
  localparam logic [2:0] OFF_TRN = 3'h4;
  localparam logic [2:0] OFF_IRQ_STAT = 3'h5;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h6;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int B_ACK = 15;
  localparam int B_TXACT = 14;
  localparam int B_BCOL = 10;
  localparam int B_GC = 9;
  localparam int B_TEN = 8;
  localparam int B_WCOL = 7;
  localparam int B_OVF = 6;
  localparam int B_DATA = 5;
  localparam int B_STOP = 4;
  localparam int B_START = 3;
  localparam int B_READ = 2;
  localparam int B_RXF = 1;
  localparam int B_TXF = 0;
  localparam int MSK_W = 10;
  localparam int B_SDA_DLY = 4;
  localparam logic [9:0] MSK_RST = 10'h000;
  localparam logic [5:0] IRQ_RST = 6'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // interrupt event bits
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_RX = 2;
  localparam int EV_TXDONE = 3;
  localparam int EV_ERR = 4;
  localparam int EV_MATCH = 5;
  localparam int EV_W = 6;

  // byte framing: eight data bits then the acknowledge slot
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int SDA_SHORT_NS = 150;
  localparam int SDA_LONG_NS = 300;
  localparam int SDA_SHORT_CYC = (SDA_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SDA_LONG_CYC = (SDA_LONG_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic mgmt_en;
    logic gc_en;
    logic ten_bit;
    logic [9:0] own_addr;
  } slave_cfg_t;

  typedef struct packed {
    logic match7;
    logic gc;
    logic hi10;
    logic lo10;
  } addr_hit_t;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX, S_SKIP
  } slave_state_t;

endpackage : i2c_status_pkg

// [core/sda_delay_line.sv]
// selectable input delay for the incoming data line
`timescale 1ns/1ps
`default_nettype none
module sda_delay_line import i2c_status_pkg::*; #(
  parameter int SHORT_CYC = SDA_SHORT_CYC,
  parameter int LONG_CYC = SDA_LONG_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // data in, select, data out
  input wire logic din,
  input wire logic long_sel,
  output logic dout_q
);

  logic [LONG_CYC-1:0] sh_q;

  // ---------------------------------------------------------------
  // tapped shift line, idles high like the bus
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sh_q <= '1;
      dout_q <= 1'b1;
    end else begin
      sh_q <= {sh_q[LONG_CYC-2:0], din};
      dout_q <= long_sel ? sh_q[LONG_CYC-1] : sh_q[SHORT_CYC-1];
    end
  end

  property p_short_delay;
    @(posedge sys_clk) disable iff (!nrst)
      $past(!long_sel) |-> dout_q == $past(din, SHORT_CYC + 1);
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("short sda delay tap wrong");

  property p_long_delay;
    @(posedge sys_clk) disable iff (!nrst)
      $past(long_sel) |-> dout_q == $past(din, LONG_CYC + 1);
  endproperty
  a_long_delay: assert property (p_long_delay)
    else $error("long sda delay tap wrong");

endmodule : sda_delay_line
`default_nettype wire

// [core/addr_match.sv]
// slave address compare with don't-care mask and reserved address guard
`timescale 1ns/1ps
`default_nettype none
module addr_match import i2c_status_pkg::*; (
  // received byte and settings
  input wire logic [7:0] rx_byte,
  input wire logic [MSK_W-1:0] mask,
  input wire slave_cfg_t cfg,
  // result
  output addr_hit_t hit
);

  logic [6:0] a7;
  logic reserved;
  logic [9:0] care;

  // management mode answers every legal address, so the mask is moot there
  assign care = cfg.mgmt_en ? 10'h000 : ~mask;
  assign a7 = rx_byte[7:1];
  // 0000xxx and 1111xxx are held back whatever the mask says
  assign reserved = (a7[6:3] == 4'h0) || (a7[6:3] == 4'hF);

  always_comb begin
    hit.gc = cfg.gc_en && (rx_byte == 8'h00);
    hit.match7 = !cfg.ten_bit && !reserved &&
                 (((a7 ^ cfg.own_addr[6:0]) & care[6:0]) == 7'h00);
    hit.hi10 = cfg.ten_bit && (a7[6:2] == 5'h1E) &&
               (((a7[1:0] ^ cfg.own_addr[9:8]) & care[9:8]) == 2'h0);
    hit.lo10 = ((rx_byte ^ cfg.own_addr[7:0]) & care[7:0]) == 8'h00;
  end

endmodule : addr_match
`default_nettype wire

// [core/i2c_status_top.sv]
// two-wire slave status flags, address masking and sda delay select
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module i2c_status_top import i2c_status_pkg::*; #(
  parameter int SHORT_CYC = SDA_SHORT_CYC,
  parameter int LONG_CYC = SDA_LONG_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  // settings and events from the control part of the module
  input wire slave_cfg_t cfg,
  input wire logic bus_collision_evt,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_q,
  // interrupt
  output logic irq_q
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_prev_q;
  logic sda_dly;
  logic pad_delay_q;

  // first stage only feeds the second; the bus idles high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_prev_q <= sda_dly;
    end
  end

  // delayed sda only judges start and stop, so late data edges after a
  // falling scl are never mistaken for a bus condition
  sda_delay_line #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_dly (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(sda_s2_q),
    .long_sel(pad_delay_q),
    .dout_q(sda_dly)
  );

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && sda_prev_q && !sda_dly;
  assign stop_det = scl_s2_q && scl_s3_q && !sda_prev_q && sda_dly;

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  slave_state_t state_q, state_d;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_sh_q, rcv_q, trn_q;
  logic ack_bit_q, txf_q, rxf_q, tx_act_q, ten_q;
  logic [MSK_W-1:0] mask_q;
  addr_hit_t hit;
  logic byte_done, ack_end, accept, is_addr, wr_trn, rd_rcv, busy;

  addr_match u_match (
    .rx_byte(sh_q),
    .mask(mask_q),
    .cfg(cfg),
    .hit(hit)
  );

  assign byte_done = scl_fall && (cnt_q == CNT_ACK);
  assign ack_end = scl_fall && (cnt_q == CNT_END);
  assign is_addr = (state_q == S_ADDR) || (state_q == S_ADDR2);
  assign wr_trn = reg_wr && (reg_addr == OFF_TRN);
  assign rd_rcv = reg_rd && (reg_addr == OFF_RCV);
  assign busy = txf_q || tx_act_q;

  // next state decided when the ack slot opens or closes
  always_comb begin
    state_d = state_q;
    accept = 1'b0;
    if (byte_done) begin
      case (state_q)
        S_ADDR: begin
          if (hit.gc || hit.match7) begin
            accept = 1'b1;
            state_d = sh_q[0] ? S_TX : S_RX;
          end else if (hit.hi10 && !sh_q[0]) begin
            accept = 1'b1;
            state_d = S_ADDR2;
          end else if (hit.hi10 && ten_q) begin
            accept = 1'b1;
            state_d = S_TX;
          end else begin
            state_d = S_SKIP;
          end
        end
        S_ADDR2: begin
          accept = hit.lo10;
          state_d = hit.lo10 ? S_RX : S_SKIP;
        end
        S_RX: begin
          // a full receive register refuses the byte with a not-acknowledge
          accept = !rxf_q;
          state_d = rxf_q ? S_SKIP : S_RX;
        end
        default: state_d = state_q;
      endcase
    end else if (ack_end && (state_q == S_TX) && ack_bit_q) begin
      state_d = S_SKIP;
    end
  end

  // state follows bus conditions first, then byte decisions
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
    end else if (start_det) begin
      state_q <= S_ADDR;
    end else if (stop_det) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit counter, receive shifter and ack sample
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      sh_q <= BYTE_RST;
      ack_bit_q <= 1'b1;
    end else if (start_det || stop_det) begin
      cnt_q <= 4'h0;
    end else if (state_q != S_IDLE) begin
      if (scl_rise && cnt_q < CNT_ACK) begin
        sh_q <= {sh_q[6:0], sda_s2_q};
        cnt_q <= cnt_q + 4'h1;
      end else if (scl_rise && cnt_q == CNT_ACK) begin
        ack_bit_q <= sda_s2_q;
        cnt_q <= CNT_END;
      end else if (ack_end) begin
        cnt_q <= 4'h0;
      end
    end
  end

  // data line drive: our ack, then transmit bits msb first
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_q <= 1'b0;
      tx_sh_q <= BYTE_RST;
      tx_act_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_q <= 1'b0;
      tx_act_q <= 1'b0;
    end else if (byte_done) begin
      sda_oe_q <= accept;
      tx_act_q <= 1'b0;
    end else if (ack_end && state_q == S_TX && !ack_bit_q) begin
      // an acknowledge in the slot starts the next transmit byte from trn_q, msb first
      sda_oe_q <= !trn_q[7];
      tx_sh_q <= {trn_q[6:0], 1'b0};
      tx_act_q <= 1'b1;
    end else if (ack_end) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall && state_q == S_TX && cnt_q < CNT_ACK) begin
      sda_oe_q <= !tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic ack_rcv_q, bcol_q, gc_q, wcol_q, ovf_q, data_q;
  logic stop_q, start_q, read_q;
  logic rx_load, ovf_set, wcol_set, stat_wr;
  assign rx_load = byte_done && state_q == S_RX && !rxf_q;
  assign ovf_set = byte_done && state_q == S_RX && rxf_q;
  assign wcol_set = wr_trn && busy;
  assign stat_wr = reg_wr && (reg_addr == OFF_STAT);

  // bus condition and transfer bookkeeping
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_rcv_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      read_q <= 1'b0;
      data_q <= 1'b0;
      gc_q <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      if (ack_end) ack_rcv_q <= ack_bit_q;
      if (start_det) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (stop_det) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
        gc_q <= 1'b0;
        ten_q <= 1'b0;
      end else if (stat_wr) begin
        if (!reg_wdata[B_START]) start_q <= 1'b0;
        if (!reg_wdata[B_STOP]) stop_q <= 1'b0;
      end
      // direction only moves once the address byte is in
      if (accept && is_addr) begin
        // a ten-bit low byte carries address bits, never a direction
        read_q <= (state_q == S_ADDR) && sh_q[0];
        data_q <= 1'b0;
      end else if (rx_load) begin
        data_q <= 1'b1;
      end
      if (accept && state_q == S_ADDR && hit.gc) gc_q <= 1'b1;
      if (accept && state_q == S_ADDR2) ten_q <= 1'b1;
    end
  end

  // error flags: hardware set wins over a clearing write of zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wcol_q <= 1'b0;
      ovf_q <= 1'b0;
      bcol_q <= 1'b0;
    end else begin
      if (wcol_set) wcol_q <= 1'b1;
      else if (stat_wr && !reg_wdata[B_WCOL]) wcol_q <= 1'b0;
      if (ovf_set) ovf_q <= 1'b1;
      else if (stat_wr && !reg_wdata[B_OVF]) ovf_q <= 1'b0;
      if (bus_collision_evt) bcol_q <= 1'b1;
      else if (stat_wr && !reg_wdata[B_BCOL]) bcol_q <= 1'b0;
    end
  end

  // buffer full flags and data registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxf_q <= 1'b0;
      txf_q <= 1'b0;
      rcv_q <= BYTE_RST;
      trn_q <= BYTE_RST;
    end else begin
      if (rx_load) begin
        rcv_q <= sh_q;
        rxf_q <= 1'b1;
      end else if (rd_rcv) begin
        rxf_q <= 1'b0;
      end
      if (wr_trn && !busy) begin
        trn_q <= reg_wdata[7:0];
        txf_q <= 1'b1;
      end else if (byte_done && state_q == S_TX) begin
        txf_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers and interrupt
  // ---------------------------------------------------------------
  logic [EV_W-1:0] irq_stat_q, irq_mask_q, ev;
  logic [DATA_W-1:0] stat_word;
  assign ev[EV_START] = start_det;
  assign ev[EV_STOP] = stop_det;
  assign ev[EV_RX] = rx_load;
  assign ev[EV_TXDONE] = byte_done && state_q == S_TX;
  assign ev[EV_ERR] = ovf_set || wcol_set || bus_collision_evt;
  assign ev[EV_MATCH] = accept && is_addr;

  always_comb begin
    stat_word = '0;
    stat_word[B_ACK] = ack_rcv_q;
    stat_word[B_TXACT] = tx_act_q;
    stat_word[B_BCOL] = bcol_q;
    stat_word[B_GC] = gc_q;
    stat_word[B_TEN] = ten_q;
    stat_word[B_WCOL] = wcol_q;
    stat_word[B_OVF] = ovf_q;
    stat_word[B_DATA] = data_q;
    stat_word[B_STOP] = stop_q;
    stat_word[B_START] = start_q;
    stat_word[B_READ] = read_q;
    stat_word[B_RXF] = rxf_q;
    stat_word[B_TXF] = txf_q;
  end

  // writable settings; only ten mask bits exist
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= MSK_RST;
      pad_delay_q <= 1'b0;
      irq_mask_q <= IRQ_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFF_MSK) mask_q <= reg_wdata[MSK_W-1:0];
      else if (reg_addr == OFF_PAD) pad_delay_q <= reg_wdata[B_SDA_DLY];
      else if (reg_addr == OFF_IRQ_MASK) irq_mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFF_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~reg_wdata[EV_W-1:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      if (reg_addr == OFF_STAT) reg_rdata_q <= stat_word;
      else if (reg_addr == OFF_MSK) reg_rdata_q <= {6'h00, mask_q};
      else if (reg_addr == OFF_PAD)
        reg_rdata_q <= {11'h000, pad_delay_q, 4'h0};
      else if (reg_addr == OFF_RCV) reg_rdata_q <= {8'h00, rcv_q};
      else if (reg_addr == OFF_TRN) reg_rdata_q <= {8'h00, trn_q};
      else if (reg_addr == OFF_IRQ_STAT) reg_rdata_q <= {10'h000, irq_stat_q};
      else if (reg_addr == OFF_IRQ_MASK) reg_rdata_q <= {10'h000, irq_mask_q};
      else reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ack_rec;
    @(posedge sys_clk) disable iff (!nrst)
      ack_end |=> ack_rcv_q == $past(ack_bit_q);
  endproperty
  a_ack_rec: assert property (p_ack_rec)
    else $error("ack status not updated at ack slot end");

  property p_start_flag;
    @(posedge sys_clk) disable iff (!nrst)
      start_det |=> start_q && !stop_q;
  endproperty
  a_start_flag: assert property (p_start_flag)
    else $error("start did not leave only begin flag set");

  property p_stop_flag;
    @(posedge sys_clk) disable iff (!nrst)
      stop_det && !start_det |=> stop_q && !start_q && !gc_q;
  endproperty
  a_stop_flag: assert property (p_stop_flag)
    else $error("stop did not leave only halt flag set");

  property p_dir;
    @(posedge sys_clk) disable iff (!nrst)
      byte_done && state_q == S_ADDR && hit.match7 |=>
        read_q == $past(sh_q[0]) ##1 (sh_q[0] ? state_q == S_TX : 1'b1);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction bit does not follow address byte");

  property p_dir_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !(byte_done && is_addr) |=> $stable(read_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction bit moved outside address byte end");

  property p_rxf;
    @(posedge sys_clk) disable iff (!nrst)
      rx_load |=> rxf_q && rcv_q == $past(sh_q);
  endproperty
  a_rxf: assert property (p_rxf)
    else $error("receive full not set with received byte");

  property p_rxf_clr;
    @(posedge sys_clk) disable iff (!nrst)
      rd_rcv && !rx_load |=> !rxf_q;
  endproperty
  a_rxf_clr: assert property (p_rxf_clr)
    else $error("receive full not cleared by read");

  property p_txf;
    @(posedge sys_clk) disable iff (!nrst)
      wr_trn && !busy |=> txf_q && trn_q == $past(reg_wdata[7:0]);
  endproperty
  a_txf: assert property (p_txf)
    else $error("transmit full not set by write");

  property p_mask_read;
    @(posedge sys_clk) disable iff (!nrst)
      reg_rd && reg_addr == OFF_MSK |=> reg_rdata_q[15:10] == 6'h00;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("unimplemented mask bits read nonzero");

  property p_reserved;
    @(posedge sys_clk) disable iff (!nrst)
      byte_done && state_q == S_ADDR && sh_q[7:4] == 4'hF && sh_q[3]
        && !start_det && !stop_det |=> state_q == S_SKIP;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved address was accepted");

  property p_errors;
    @(posedge sys_clk) disable iff (!nrst)
      ovf_set || wcol_set |=> (ovf_q || wcol_q) ##1 (ovf_q || wcol_q);
  endproperty
  a_errors: assert property (p_errors)
    else $error("error flag not held after event");

endmodule : i2c_status_top
`default_nettype wire

// [dv/i2c_master_model.sv]
// bus master model driving the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // clock
  input wire logic sys_clk,
  // bus: scl driven, sda pulled low or released
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // sda moves ten cycles before scl rises, so the slow input path never
  // sees an edge while scl is high
  task automatic bit_clk(input logic b, output logic s);
    scl <= 1'b0;
    wt(2);
    sda_low <= ~b;
    wt(10);
    scl <= 1'b1;
    wt(4);
    s = sda;
  endtask : bit_clk

  // stp 0: start or repeated start, stp 1: stop
  task automatic cond(input logic stp);
    scl <= 1'b0;
    wt(2);
    sda_low <= stp;
    wt(10);
    scl <= 1'b1;
    wt(12);
    sda_low <= ~stp;
    wt(12);
  endtask : cond

  // eight bits msb first, then the acknowledge clock; all ones reads
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(tx[i], s);
      rx[i] = s;
    end
    bit_clk(mack, s);
    ack = ~s;
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the two-wire status block
`timescale 1ns/1ps
`default_nettype none
module testbench import i2c_status_pkg::*;;
  logic sys_clk, nrst, reg_wr, reg_rd, bcol, ak;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, d;
  logic [7:0] rx;
  slave_cfg_t cfg;
  wire [DATA_W-1:0] rdata;
  wire scl, m_low, sda_oe, sda_out, irq, sda;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // open drain with pull-up
  assign sda = ~(m_low | sda_oe);

  i2c_status_top #(.SHORT_CYC(2), .LONG_CYC(4)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdata), .cfg(cfg), .bus_collision_evt(bcol),
    .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out),
    .sda_oe_q(sda_oe), .irq_q(irq));
  i2c_master_model M (.sys_clk(sys_clk), .scl(scl), .sda_low(m_low),
    .sda(sda));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask : rd

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic sb(input int b, input logic e, input string n);
    rd(OFF_STAT, d);
    chk(n, {15'h0000, e}, {15'h0000, d[b]});
  endtask : sb

  task automatic probe(input logic [7:0] a, input logic e, input string n);
    M.cond(1'b0);
    M.xfer(a, 1'b1, rx, ak);
    M.cond(1'b1);
    chk(n, {15'h0000, e}, {15'h0000, ak});
  endtask : probe

  task automatic t_regs();
    rd(OFF_MSK, d);
    chk("msk rst", 16'h0000, d);
    wr(OFF_MSK, 16'hFFFF);
    rd(OFF_MSK, d);
    chk("msk wr", 16'h03FF, d);
    wr(OFF_PAD, 16'hFFFF);
    rd(OFF_PAD, d);
    chk("pad wr", 16'h0010, d);
    wr(3'h7, 16'hFFFF);
    rd(3'h7, d);
    chk("unmapped", 16'h0000, d);
  endtask : t_regs

  // long sda delay still in force here
  task automatic t_match();
    cfg <= {3'b000, 10'h050};
    wr(OFF_MSK, 16'h0001);
    probe(8'hA2, 1'b1, "masked");
    probe(8'hA4, 1'b0, "exact");
    sb(B_ACK, 1'b1, "nack seen");
    wr(OFF_MSK, 16'h03FF);
    probe(8'h00, 1'b0, "gc off");
    probe(8'h02, 1'b0, "reserved");
    probe(8'hF8, 1'b0, "reserved hi");
    cfg <= {3'b010, 10'h050};
    probe(8'h00, 1'b1, "gc on");
    cfg <= {3'b100, 10'h050};
    wr(OFF_MSK, 16'h0000);
    probe(8'hA4, 1'b1, "mgmt");
  endtask : t_match

  task automatic t_write();
    cfg <= {3'b000, 10'h050};
    wr(OFF_PAD, 16'h0000);
    wr(OFF_IRQ_STAT, 16'h003F);
    wr(OFF_IRQ_MASK, 16'h0004);
    M.cond(1'b0);
    sb(B_START, 1'b1, "start");
    M.xfer(8'hA0, 1'b1, rx, ak);
    sb(B_READ, 1'b0, "dir wr");
    chk("irq masked", 16'h0000, {15'h0000, irq});
    M.xfer(8'hA5, 1'b1, rx, ak);
    sb(B_ACK, 1'b0, "ack seen");
    sb(B_RXF, 1'b1, "rxf set");
    chk("irq on", 16'h0001, {15'h0000, irq});
    rd(OFF_RCV, d);
    chk("rcv", 16'h00A5, d);
    sb(B_RXF, 1'b0, "rxf clr");
    wr(OFF_IRQ_STAT, 16'h0004);
    rd(OFF_IRQ_STAT, d);
    chk("irq w1c", 16'h0000, d & 16'h0004);
    chk("irq off", 16'h0000, {15'h0000, irq});
    M.cond(1'b1);
    sb(B_STOP, 1'b1, "stop");
    sb(B_START, 1'b0, "start clr");
  endtask : t_write

  // second byte arrives while the first is unread
  task automatic t_ovf();
    M.cond(1'b0);
    M.xfer(8'hA0, 1'b1, rx, ak);
    M.xfer(8'h11, 1'b1, rx, ak);
    M.xfer(8'h22, 1'b1, rx, ak);
    chk("ovf nack", 16'h0000, {15'h0000, ak});
    M.cond(1'b1);
    sb(B_OVF, 1'b1, "ovf held");
    wr(OFF_STAT, 16'h0000);
    sb(B_OVF, 1'b0, "ovf clr");
    rd(OFF_RCV, d);
    chk("rcv kept", 16'h0011, d);
  endtask : t_ovf

  task automatic t_read();
    wr(OFF_TRN, 16'h003C);
    sb(B_TXF, 1'b1, "txf set");
    wr(OFF_TRN, 16'h00FF);
    sb(B_WCOL, 1'b1, "wcol");
    M.cond(1'b0);
    M.xfer(8'hA1, 1'b1, rx, ak);
    sb(B_READ, 1'b1, "dir rd");
    M.xfer(8'hFF, 1'b1, rx, ak);
    chk("tx byte", 16'h003C, {8'h00, rx});
    M.cond(1'b0);
    sb(B_READ, 1'b1, "dir held");
    M.xfer(8'hA0, 1'b1, rx, ak);
    M.cond(1'b1);
    sb(B_READ, 1'b0, "dir wr2");
    sb(B_TXF, 1'b0, "txf clr");
  endtask : t_read

  // ten-bit write; own address is the complement of the earlier one
  task automatic t_ten();
    cfg <= {3'b001, 10'h3AF};
    M.cond(1'b0);
    M.xfer(8'hF6, 1'b1, rx, ak);
    chk("ten hi", 16'h0001, {15'h0000, ak});
    M.xfer(8'hAF, 1'b1, rx, ak);
    chk("ten lo", 16'h0001, {15'h0000, ak});
    sb(B_TEN, 1'b1, "ten flag");
    sb(B_READ, 1'b0, "ten dir");
    M.cond(1'b1);
    bcol <= 1'b1;
    @(posedge sys_clk);
    bcol <= 1'b0;
    sb(B_BCOL, 1'b1, "bcol");
    chk("sda out", 16'h0000, {15'h0000, sda_out});
  endtask : t_ten

  task automatic print_verdict();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end

  // collision event stays idle except for one pulse in t_ten
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    cfg = '0;
    bcol = 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_regs();
    t_match();
    t_write();
    t_ovf();
    t_read();
    t_ten();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
